// File: rtl/ssc_pkg.sv
// Constants and carrier types for the servo signal conditioning block.
// Assumes one 20 MHz clock and a synchronous active-high reset.
// Summary of operation
// [R1] Averaging depth selectable from two to four successive samples.
// [R2] Enhancement averages both command and position paths together.
// [R3] Host sets equal depth on both axes when shear is nonzero.
// [R4] Low-frequency velocity is position difference between successive samples.
// [R5] Low-frequency filter: bypass, one-pole or two-pole low-pass, programmable cutoff.
// [R6] High-frequency velocity accumulates coil current, optionally blended with position.
// [R7] High-frequency velocity passes a selectable high-pass with programmable cutoff.
// [R8] Host sets high-frequency cutoff somewhat above low-frequency cutoff.
// [R9] Two output filters: bypass, one-pole, two-pole, notch or phase-lead.
// [R10] Each output filter has its own type, frequency and quality settings.
// [R11] Scale maps positive full-scale code to degrees, negative symmetric.
// [R12] Programmable degree offset is added to the scaled position.
// [R13] Fault raised when position exceeds the positive limit.
// [R14] Fault raised when position falls below the negative limit.
// [R15] Fault shuts drive down, then a timed restart runs before resuming.
// [R16] Limits compare the internal scaled, offset position, its own sign.
// [R17] Pipeline sustains 200 kHz both axes, 300 kHz one axis.
// [R18] Every stage advances once per strobe; reset zeroes all filter and history state, sequencer wakes in run.
// [R19] Fault flag holds until restart ends, then clears; checking resumes.
package ssc_pkg;
    localparam int DW = 16;
    localparam int SHIFT = 12;
    localparam int FIFO_DEPTH = 4;
    localparam logic [31:0] CLOCK_HZ = 32'h0131_2D00;
    localparam int RESTART_MS = 3000;
    localparam int RESTART_CYCLES = RESTART_MS * (20000000 / 1000);
    localparam logic [15:0] RESET_WORD = 16'h0000;

    typedef enum logic [1:0] {
        SSC_LF_BYPASS = 2'h0,
        SSC_LF_ONE_POLE = 2'h1,
        SSC_LF_TWO_POLE = 2'h2
    } ssc_lf_e;

    typedef enum logic [2:0] {
        SSC_OF_BYPASS = 3'h0,
        SSC_OF_ONE_POLE = 3'h1,
        SSC_OF_TWO_POLE = 3'h2,
        SSC_OF_NOTCH = 3'h3,
        SSC_OF_LEAD = 3'h4
    } ssc_of_e;

    typedef enum logic [2:0] {
        SSC_RUN = 3'b001,
        SSC_SHUT = 3'b010,
        SSC_RESTART = 3'b100
    } ssc_state_e;

    typedef struct packed {
        logic signed [15:0] command;
        logic signed [15:0] position;
        logic signed [15:0] current;
    } ssc_sample_s;

    typedef struct packed {
        logic signed [15:0] command;
        logic signed [15:0] lf_vel;
        logic signed [15:0] hf_vel;
        logic signed [15:0] drive;
        logic signed [15:0] position;
    } ssc_out_s;

    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] freq;
        logic [15:0] quality;
    } ssc_filt_s;
endpackage

// File: rtl/ssc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ssc_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] rd, wr, next_rd, next_wr;
    logic [AW:0] count, next_count;
    logic push, pop, next_in_ready;

    // Pointer and occupancy update
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        next_wr = push ? ((wr == AW'(DEPTH - 1)) ? '0 : wr + 1'b1) : wr;
        next_rd = pop ? ((rd == AW'(DEPTH - 1)) ? '0 : rd + 1'b1) : rd;
        next_count = count + (AW + 1)'(push) - (AW + 1)'(pop);
        next_in_ready = next_count != (AW + 1)'(DEPTH); // Honest full, registered for a clean port
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rd <= '0;
            wr <= '0;
            count <= '0;
            in_ready <= 1'b1;
        end else begin
            rd <= next_rd;
            wr <= next_wr;
            count <= next_count;
            in_ready <= next_in_ready;
        end
        if (push) begin
            mem[wr] <= in_data;
        end
    end

    assign out_valid = count != '0;
    assign out_data = mem[rd];
endmodule
`default_nettype wire

// File: rtl/ssc_core.sv
// One axis of servo signal conditioning: averaging, damping filters,
// output filters, position scaling and the position fault detector.
// Assumes synchronous sample inputs held with a valid/ready handshake.
`timescale 1ns/10ps
`default_nettype none
module ssc_core #(
    parameter int RESTART_CYCLES = ssc_pkg::RESTART_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire ssc_pkg::ssc_sample_s sample,
    input wire logic sample_valid,
    output logic sample_ready,
    input wire logic enhance_enable,
    input wire logic [2:0] average_depth,
    input wire logic [1:0] lf_kind,
    input wire logic [15:0] lf_cutoff,
    input wire logic [1:0] hf_kind,
    input wire logic [15:0] hf_cutoff,
    input wire logic observer_enable,
    input wire logic [15:0] observer_gain,
    input wire ssc_pkg::ssc_filt_s filt1,
    input wire ssc_pkg::ssc_filt_s filt2,
    input wire logic signed [15:0] position_scale,
    input wire logic signed [15:0] position_offset,
    input wire logic signed [15:0] limit_positive,
    input wire logic signed [15:0] limit_negative,
    output ssc_pkg::ssc_out_s result,
    output logic result_valid,
    output logic drive_enable,
    output logic servo_fault
);
    localparam int W = 32;
    typedef logic signed [W-1:0] ssc_acc_t;

    ssc_pkg::ssc_sample_s fifo_sample;
    logic fifo_valid;
    logic step;

    // Input words queue here so a burst of samples is never dropped [R17]
    ssc_fifo #(.WIDTH($bits(ssc_pkg::ssc_sample_s)), .DEPTH(ssc_pkg::FIFO_DEPTH)) u_fifo (
        .clock(clock),
        .reset(reset),
        .in_data(sample),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .out_data(fifo_sample),
        .out_valid(fifo_valid),
        .out_ready(1'b1)
    );
    assign step = fifo_valid; // Exactly one advance per sample [R18]

    // Fixed-point multiply with Q12 coefficient
    function automatic ssc_acc_t mulq(input ssc_acc_t a, input logic signed [16:0] k);
        logic signed [48:0] p;
        p = a * k;
        return ssc_acc_t'(p >>> ssc_pkg::SHIFT);
    endfunction

    // Saturate to the output word
    function automatic logic signed [15:0] sat(input ssc_acc_t a);
        if (a > 32767) begin
            return 16'sh7FFF;
        end else if (a < -32768) begin
            return -16'sh8000;
        end
        return a[15:0];
    endfunction

    // ---- Averaging history; depth clamps to 2..4 [R1]
    logic signed [15:0] cmd_hist [3];
    logic signed [15:0] pos_hist [3];
    logic signed [15:0] next_cmd_hist [3];
    logic signed [15:0] next_pos_hist [3];
    ssc_acc_t cmd_avg, pos_avg;
    logic [2:0] depth;

    always_comb begin
        depth = (average_depth < 3'h2) ? 3'h2 : ((average_depth > 3'h4) ? 3'h4 : average_depth); // [R1]
        next_cmd_hist = cmd_hist;
        next_pos_hist = pos_hist;
        if (step) begin
            next_cmd_hist[0] = fifo_sample.command;
            next_pos_hist[0] = fifo_sample.position;
            for (int i = 1; i < 3; i++) begin
                next_cmd_hist[i] = cmd_hist[i-1];
                next_pos_hist[i] = pos_hist[i-1];
            end
        end
        // Same depth on both paths keeps command and position aligned [R2]
        cmd_avg = ssc_acc_t'(fifo_sample.command) + ssc_acc_t'(cmd_hist[0]);
        pos_avg = ssc_acc_t'(fifo_sample.position) + ssc_acc_t'(pos_hist[0]);
        if (depth >= 3'h3) begin
            cmd_avg = cmd_avg + ssc_acc_t'(cmd_hist[1]);
            pos_avg = pos_avg + ssc_acc_t'(pos_hist[1]);
        end
        if (depth == 3'h4) begin
            cmd_avg = cmd_avg + ssc_acc_t'(cmd_hist[2]);
            pos_avg = pos_avg + ssc_acc_t'(pos_hist[2]);
        end
        // Divide by depth; three uses a Q12 reciprocal rounded up so non-negative exact thirds up to 2047 stay exact
        unique case (depth)
            3'h2: begin
                cmd_avg = cmd_avg >>> 1;
                pos_avg = pos_avg >>> 1;
            end
            3'h3: begin
                cmd_avg = mulq(cmd_avg, 17'sh0556);
                pos_avg = mulq(pos_avg, 17'sh0556);
            end
            default: begin
                cmd_avg = cmd_avg >>> 2;
                pos_avg = pos_avg >>> 2;
            end
        endcase
        if (!enhance_enable) begin
            cmd_avg = ssc_acc_t'(fifo_sample.command);
            pos_avg = ssc_acc_t'(fifo_sample.position);
        end
    end

    // ---- Position scale and offset
    ssc_acc_t pos_deg;
    always_comb begin
        // Full-scale code maps to scale degrees, symmetric in sign [R11]
        pos_deg = ssc_acc_t'((64'(signed'(pos_avg)) * 64'(signed'(position_scale))) >>> 15);
        pos_deg = pos_deg + ssc_acc_t'(position_offset); // [R12]
    end

    // ---- Low-frequency velocity: difference then optional low-pass
    ssc_acc_t pos_prev, lf_s1, lf_s2, hf_int, hf_lp;
    ssc_acc_t next_pos_prev, next_lf_s1, next_lf_s2, next_hf_int, next_hf_lp;
    ssc_acc_t lf_raw, lf_out, hf_in, hf_out;
    logic signed [16:0] lf_k, hf_k;

    always_comb begin
        lf_k = signed'({1'b0, lf_cutoff});
        hf_k = signed'({1'b0, hf_cutoff});
        lf_raw = pos_deg - pos_prev; // [R4]
        next_pos_prev = step ? pos_deg : pos_prev;
        next_lf_s1 = step ? lf_s1 + mulq(lf_raw - lf_s1, lf_k) : lf_s1;
        next_lf_s2 = step ? lf_s2 + mulq(next_lf_s1 - lf_s2, lf_k) : lf_s2;
        unique case (lf_kind)
            2'h1: lf_out = next_lf_s1; // [R5]
            2'h2: lf_out = next_lf_s2; // [R5]
            default: lf_out = lf_raw;
        endcase
        // Current integration, with optional position correction [R6]
        next_hf_int = hf_int + ssc_acc_t'(fifo_sample.current);
        if (observer_enable) begin
            next_hf_int = next_hf_int + mulq(pos_deg - (hf_int >>> 8), signed'({1'b0, observer_gain}));
        end
        if (!step) begin
            next_hf_int = hf_int;
        end
        hf_in = next_hf_int >>> 8;
        // High-pass as input minus its low-pass tracker [R7]
        next_hf_lp = step ? hf_lp + mulq(hf_in - hf_lp, hf_k) : hf_lp;
        unique case (hf_kind)
            2'h1: hf_out = hf_in - next_hf_lp; // [R7]
            2'h2: hf_out = (hf_in - next_hf_lp) - mulq(hf_in - next_hf_lp, hf_k); // [R7]
            default: hf_out = hf_in;
        endcase
    end

    // ---- Two output filters on the drive path [R9]
    ssc_acc_t of_s1 [2], of_s2 [2], next_of_s1 [2], next_of_s2 [2], of_out [3];
    ssc_pkg::ssc_filt_s filt [2];
    assign filt[0] = filt1; // [R10]
    assign filt[1] = filt2; // [R10]
    assign of_out[0] = cmd_avg - pos_deg;

    for (genvar g = 0; g < 2; g++) begin : g_of
        always_comb begin
            logic signed [16:0] k, q;
            ssc_acc_t a, b;
            k = signed'({1'b0, filt[g].freq});
            q = signed'({1'b0, filt[g].quality});
            a = of_s1[g] + mulq(of_out[g] - of_s1[g], k);
            b = of_s2[g] + mulq(a - of_s2[g], k);
            next_of_s1[g] = step ? a : of_s1[g];
            next_of_s2[g] = step ? b : of_s2[g];
            unique case (filt[g].kind)
                3'h1: of_out[g+1] = a; // [R9]
                3'h2: of_out[g+1] = b; // [R9]
                3'h3: of_out[g+1] = of_out[g] - mulq(of_out[g] - b, q); // [R9]
                3'h4: of_out[g+1] = of_out[g] + mulq(of_out[g] - a, q); // [R9]
                default: of_out[g+1] = of_out[g]; // Bypass, input passed through; filter state still advances [R9]
            endcase
        end
    end

    // ---- Fault detector and restart sequencer
    ssc_pkg::ssc_state_e state, next_state;
    logic [31:0] timer, next_timer;
    logic over;

    always_comb begin
        // Own sign convention, after scale and offset [R16]
        over = step && ((pos_deg > ssc_acc_t'(limit_positive)) // [R13]
            || (pos_deg < ssc_acc_t'(limit_negative))); // [R14]
        next_state = state;
        next_timer = timer;
        unique case (state)
            ssc_pkg::SSC_RUN: begin
                if (over) begin
                    next_state = ssc_pkg::SSC_SHUT; // [R15]
                end
            end
            ssc_pkg::SSC_SHUT: begin
                next_state = ssc_pkg::SSC_RESTART;
                next_timer = '0;
            end
            ssc_pkg::SSC_RESTART: begin
                next_timer = timer + 32'h0000_0001;
                if (timer >= 32'(RESTART_CYCLES - 1)) begin
                    next_state = ssc_pkg::SSC_RUN; // Fault clears, checking resumes [R19]
                end
            end
            default: next_state = ssc_pkg::SSC_RUN;
        endcase
    end

    // Output words; the drive word is forced to zero once shutdown starts
    ssc_pkg::ssc_out_s next_result;
    logic next_result_valid, next_drive_enable, next_servo_fault;

    always_comb begin
        next_result = result;
        next_result_valid = step;
        if (step) begin
            next_result.command = sat(cmd_avg);
            next_result.position = sat(pos_deg);
            next_result.lf_vel = sat(lf_out);
            next_result.hf_vel = sat(hf_out);
            next_result.drive = (next_state == ssc_pkg::SSC_RUN) ? sat(of_out[2]) : 16'h0000; // [R15]
        end
        next_drive_enable = next_state == ssc_pkg::SSC_RUN; // [R15]
        next_servo_fault = next_state != ssc_pkg::SSC_RUN; // [R19]
    end

    // Averaging history; reset clears it to zero [R18]
    always_ff @(posedge clock) begin
        if (reset) begin
            cmd_hist <= '{default: '0};
            pos_hist <= '{default: '0};
        end else begin
            cmd_hist <= next_cmd_hist;
            pos_hist <= next_pos_hist;
        end
    end

    // Damping filter state; reset clears it to zero [R18]
    always_ff @(posedge clock) begin
        if (reset) begin
            pos_prev <= '0;
            lf_s1 <= '0;
            lf_s2 <= '0;
            hf_int <= '0;
            hf_lp <= '0;
        end else begin
            pos_prev <= next_pos_prev;
            lf_s1 <= next_lf_s1;
            lf_s2 <= next_lf_s2;
            hf_int <= next_hf_int;
            hf_lp <= next_hf_lp;
        end
    end

    // Output filter state; reset clears it to zero [R18]
    always_ff @(posedge clock) begin
        if (reset) begin
            of_s1 <= '{default: '0};
            of_s2 <= '{default: '0};
        end else begin
            of_s1 <= next_of_s1;
            of_s2 <= next_of_s2;
        end
    end

    // Sequencer wakes in run, so the drive comes up one edge after reset
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ssc_pkg::SSC_RUN;
            timer <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Every port is a flop; drive stays off while reset holds
    always_ff @(posedge clock) begin
        if (reset) begin
            result <= '0;
            result_valid <= 1'b0;
            drive_enable <= 1'b0;
            servo_fault <= 1'b0;
        end else begin
            result <= next_result;
            result_valid <= next_result_valid;
            drive_enable <= next_drive_enable;
            servo_fault <= next_servo_fault;
        end
    end
endmodule
`default_nettype wire

// File: tb/ssc_adc_model.sv
// Converter model feeding one axis with command, position and current words.
// Assumes the sample handshake of ssc_core; words are offered after an edge.
`timescale 1ns/10ps
`default_nettype none
module ssc_adc_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic sample_ready,
    output ssc_pkg::ssc_sample_s sample,
    output logic sample_valid
);
    ssc_pkg::ssc_sample_s last;

    // Idle lines at time zero
    initial begin
        last = '0;
        sample = '0;
        sample_valid = 1'b0;
    end

    // Offer one word, hold it until taken or 20 edges pass, then scramble the idle bus
    task automatic send(input logic [15:0] c, input logic [15:0] p, input logic [15:0] i, input int gap,
                        output bit ok);
        int n;
        repeat (gap) @(posedge clock);
        #1;
        last = {c, p, i};
        sample = last;
        sample_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (sample_ready !== 1'b1 && n < 20);
        ok = (sample_ready === 1'b1) && (reset === 1'b0); // A take during reset is lost
        #1;
        sample_valid = 1'b0;
        sample = ~last; // Stale word must not look valid
    endtask
endmodule
`default_nettype wire

// File: tb/ssc_core_sva.sv
// Port-level checker for one conditioning axis.
// Assumes it is bound to ssc_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module ssc_core_sva #(
    parameter int RESTART_CYCLES = ssc_pkg::RESTART_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic sample_ready,
    input wire ssc_pkg::ssc_out_s result,
    input wire logic result_valid,
    input wire logic drive_enable,
    input wire logic servo_fault,
    input wire logic signed [15:0] limit_positive,
    input wire logic signed [15:0] limit_negative
);
    logic [1:0] took;
    int fault_len;

    // Take history and fault length; a counter keeps long restarts cheap
    always_ff @(posedge clock) begin
        if (reset) begin
            took <= 2'h0;
            fault_len <= 0;
        end else begin
            took <= {took[0], sample_valid & sample_ready};
            fault_len <= servo_fault ? fault_len + 1 : 0;
        end
    end

    a_answer_two_late: assert property (@(posedge clock) disable iff (reset)
        sample_valid && sample_ready |-> ##2 result_valid) else $error("result missing");
    a_no_spurious_result: assert property (@(posedge clock) disable iff (reset)
        result_valid |-> took[1]) else $error("result without sample");
    a_fault_above_limit: assert property (@(posedge clock) disable iff (reset)
        result_valid && !$past(servo_fault) && result.position > limit_positive |-> servo_fault)
        else $error("no fault above limit");
    a_fault_below_limit: assert property (@(posedge clock) disable iff (reset)
        result_valid && !$past(servo_fault) && result.position < limit_negative |-> servo_fault)
        else $error("no fault below limit");
    a_fault_has_cause: assert property (@(posedge clock) disable iff (reset)
        $rose(servo_fault) |-> result_valid
        && (result.position > limit_positive || result.position < limit_negative))
        else $error("fault inside limits");
    a_restart_length: assert property (@(posedge clock) disable iff (reset)
        $fell(servo_fault) |-> fault_len == RESTART_CYCLES + 1) else $error("restart length wrong");
    a_fault_drive_off: assert property (@(posedge clock) disable iff (reset)
        servo_fault |-> !drive_enable) else $error("drive on during fault");
    a_restart_rearms: assert property (@(posedge clock) disable iff (reset)
        $fell(servo_fault) |-> drive_enable) else $error("drive not restored");
    a_fault_drive_zero: assert property (@(posedge clock) disable iff (reset)
        servo_fault && $past(servo_fault) |-> result.drive == 16'h0000) else $error("drive word not zero");
    a_wake_after_reset: assert property (@(posedge clock) disable iff (reset)
        $fell(reset) |=> drive_enable) else $error("drive not enabled after reset");
endmodule

bind ssc_core ssc_core_sva #(.RESTART_CYCLES(RESTART_CYCLES)) sva (
    .clock(clock),
    .reset(reset),
    .sample_valid(sample_valid),
    .sample_ready(sample_ready),
    .result(result),
    .result_valid(result_valid),
    .drive_enable(drive_enable),
    .servo_fault(servo_fault),
    .limit_positive(limit_positive),
    .limit_negative(limit_negative)
);
`default_nettype wire

// File: tb/servo_signal_conditioning_bench.sv
// Self-checking bench for one conditioning axis with converter model.
// Assumes a short restart parameter; the FIFO drains every cycle here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %0t got %0h expected %0h", $time, g, e); end end
module servo_signal_conditioning_bench;
    localparam int RC = 20;
    logic clock = 1'b0;
    logic reset = 1'b1;
    ssc_pkg::ssc_sample_s sample;
    logic sample_valid, sample_ready, result_valid, drive_enable, servo_fault;
    logic enhance_enable, observer_enable;
    logic [2:0] average_depth;
    logic [1:0] lf_kind, hf_kind;
    logic [15:0] lf_cutoff, hf_cutoff, observer_gain, e;
    logic signed [15:0] position_scale, position_offset, limit_positive, limit_negative;
    ssc_pkg::ssc_filt_s filt1, filt2;
    ssc_pkg::ssc_out_s result, r;
    ssc_pkg::ssc_out_s rq[$];
    logic [2:0] dep[4] = '{3'h1, 3'h3, 3'h4, 3'h7};
    int fail_count = 0;
    int checks = 0;
    int run = 0;
    int last_run = 0;
    int de;
    bit ok;

    always #25 clock = ~clock;

    ssc_core #(.RESTART_CYCLES(RC)) dut (.clock(clock), .reset(reset), .sample(sample),
        .sample_valid(sample_valid), .sample_ready(sample_ready), .enhance_enable(enhance_enable),
        .average_depth(average_depth), .lf_kind(lf_kind), .lf_cutoff(lf_cutoff), .hf_kind(hf_kind),
        .hf_cutoff(hf_cutoff), .observer_enable(observer_enable), .observer_gain(observer_gain),
        .filt1(filt1), .filt2(filt2), .position_scale(position_scale), .position_offset(position_offset),
        .limit_positive(limit_positive), .limit_negative(limit_negative), .result(result),
        .result_valid(result_valid), .drive_enable(drive_enable), .servo_fault(servo_fault));
    ssc_adc_model adc (.clock(clock), .reset(reset), .sample_ready(sample_ready), .sample(sample),
        .sample_valid(sample_valid));

    // Queue answers and measure fault runs independent of task timing
    always @(posedge clock) begin
        if (result_valid === 1'b1) rq.push_back(result);
        if (servo_fault === 1'b1) run++;
        else if (run != 0) begin
            last_run = run;
            run = 0;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic hang();
        fail_count++;
        $display("CHECK FAILED %0t wait ran out", $time);
        stop_test();
    endtask

    // Wait a bounded time for the next answer
    task automatic get();
        int n;
        n = 0;
        while (rq.size() == 0 && n < 8) begin
            tick(1);
            n++;
        end
        if (rq.size() == 0) hang();
        r = rq.pop_front();
    endtask

    task automatic xfer(input logic [15:0] c, input logic [15:0] p, input logic [15:0] i);
        adc.send(c, p, i, 0, ok);
        get();
    endtask

    task automatic do_reset();
        reset = 1'b1;
        tick(3);
        `CHK(result, 80'h0)
        `CHK(drive_enable, 1'b0)
        reset = 1'b0;
        rq.delete();
        tick(2);
        `CHK(drive_enable, 1'b1)
    endtask

    // Drive stays off for the whole restart, then returns with the flag
    task automatic fault_run();
        int n;
        n = 0;
        while (servo_fault === 1'b1 && n < 100) begin
            `CHK(drive_enable, 1'b0)
            tick(1);
            n++;
        end
        if (n == 100) hang();
        tick(1);
        `CHK(last_run, RC + 1)
        `CHK(drive_enable, 1'b1)
    endtask

    initial begin
        enhance_enable = 1'b0;
        observer_enable = 1'b0;
        average_depth = 3'h2;
        lf_kind = 2'h0;
        hf_kind = 2'h0;
        lf_cutoff = 16'h0800;
        hf_cutoff = 16'h0C00;
        observer_gain = 16'h0100;
        filt1 = '0;
        filt2 = '0;
        position_scale = 16'sh4000;
        position_offset = 16'sh000A;
        limit_positive = 16'sh7FFF;
        limit_negative = 16'sh8000;
        do_reset();
        $display("test reset done");
        // Scaling, offset and full-scale symmetry with averaging and filters bypassed; observer on for the negative end
        xfer(16'h0064, 16'h00C8, 16'h0000);
        xfer(16'h0064, 16'h00C8, 16'h0000);
        `CHK(r.command, 16'h0064)
        `CHK(r.position, 16'h006E)
        `CHK(r.lf_vel, 16'h0000)
        `CHK(r.hf_vel, 16'h0000)
        `CHK(r.drive, 16'hFFF6)
        xfer(16'h0064, 16'h7FFF, 16'h0000);
        `CHK(r.position, 16'h4009)
        `CHK(r.lf_vel !== 16'h0000, 1'b1)
        observer_enable = 1'b1;
        xfer(16'h0064, 16'h8000, 16'h2000);
        xfer(16'h0064, 16'h8000, 16'h2000);
        `CHK(r.position, 16'hC00A)
        `CHK(r.hf_vel !== 16'h0000, 1'b1)
        observer_enable = 1'b0;
        $display("test scaling done");
        // Bursts of four back to back; depths out of range clamp
        enhance_enable = 1'b1;
        for (int k = 0; k < 4; k++) begin
            average_depth = dep[k];
            de = (dep[k] < 3'h2) ? 2 : (dep[k] > 3'h4) ? 4 : int'(dep[k]);
            e = 16'(400 - (de - 1) * 50);
            for (int j = 1; j <= 4; j++) begin
                adc.send(16'(j * 100), 16'(j * 100), 16'h0000, 0, ok);
                `CHK(ok, 1'b1)
            end
            repeat (4) get();
            `CHK(r.command, e)
            `CHK(r.position, 16'((e >> 1) + 10))
        end
        enhance_enable = 1'b0;
        $display("test averaging done");
        // Every filter kind settles to zero on a silent input
        do_reset();
        position_offset = 16'sh0000;
        for (int k = 0; k < 5; k++) begin
            filt1 = '{3'(k), 16'h0400, 16'h0B50};
            filt2 = '{3'(4 - k), 16'h0800, 16'h1000};
            lf_kind = 2'(k % 3);
            hf_kind = 2'((k + 1) % 3);
            xfer(16'h0000, 16'h0000, 16'h0000);
            `CHK(r.drive, 16'h0000)
            `CHK(r.lf_vel, 16'h0000)
            `CHK(r.hf_vel, 16'h0000)
        end
        // A quarter-gain one-pole passes a quarter of a fresh step
        filt1 = '{3'h1, 16'h0400, 16'h0000};
        filt2 = '0;
        xfer(16'h0100, 16'h0000, 16'h0000);
        `CHK(r.drive, 16'h0040)
        $display("test filters done");
        // Limits are strict and judged after scale and offset
        position_offset = 16'sh000A;
        limit_positive = 16'sh03E8;
        limit_negative = 16'shFC18;
        xfer(16'h0000, 16'h07BC, 16'h0000);
        `CHK(r.position, 16'h03E8)
        `CHK(servo_fault, 1'b0)
        xfer(16'h0000, 16'h07BE, 16'h0000);
        `CHK(servo_fault, 1'b1)
        fault_run();
        xfer(16'h0000, 16'hF81C, 16'h0000);
        `CHK(r.position, 16'hFC18)
        `CHK(servo_fault, 1'b0)
        xfer(16'h0000, 16'hF81A, 16'h0000);
        `CHK(servo_fault, 1'b1)
        fault_run();
        $display("test faults done");
        stop_test();
    end
endmodule
`default_nettype wire
